// ### sim/umie_node.sv
// Purpose: Remote serial node on the far side of the link
// Assumes: Bit time is a whole number of clocks
// Notes: Line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module umie_node #(
  parameter int BIT_CYC = 32
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // ninth bit is address flag, no parity
  task automatic send(input logic [8:0] v, input int nb);
    for (int i = 0; i < nb + 2; i++) begin
      line_out <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : v[i - 1];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask : send
  task automatic recv(output logic [7:0] v);
    int k;
    k = 0;
    while (line_in !== 1'b0 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      v[i] = line_in;
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask : recv
endmodule : umie_node
`default_nettype wire

// ### sim/umie_uart_sva.sv
// Purpose: Port-level checks for the serial port
// Assumes: Control state mirrored from register writes seen here
// Notes: Infrared shape checks only with a divisor of zero or one
`timescale 1ns/1ps
`default_nettype none
module umie_uart_sva (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic SERIAL_IN_PIN,
  input wire logic SERIAL_OUT_PIN,
  input wire logic RX_IRQ
);
  logic ir_ff, nxt_ir;
  logic [7:0] brh_ff, brl_ff, node_ff, nxt_brh, nxt_brl, nxt_node;
  logic ir1, unmapped;
  always_comb begin
    nxt_ir = ir_ff;
    nxt_brh = brh_ff;
    nxt_brl = brl_ff;
    nxt_node = node_ff;
    if (WR && CE && ADDR == 12'hf43) nxt_ir = WDATA[1];
    if (WR && CE && ADDR == 12'hf46) nxt_brh = WDATA;
    if (WR && CE && ADDR == 12'hf47) nxt_brl = WDATA;
    if (WR && CE && ADDR == 12'hf44) nxt_node = WDATA;
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ir_ff <= 1'b0;
      brh_ff <= 8'h00;
      brl_ff <= 8'h01;
      node_ff <= 8'h00;
    end else begin
      ir_ff <= nxt_ir;
      brh_ff <= nxt_brh;
      brl_ff <= nxt_brl;
      node_ff <= nxt_node;
    end
  end
  assign ir1 = ir_ff && brh_ff == 8'h00 && brl_ff <= 8'h01;
  assign unmapped = ADDR[11:4] != 8'hf4 || ADDR[3:0] > 4'h7 || ADDR[3:0] == 4'h5;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  AST_RDATA_IDLE: assert property ($past(CE) && !$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_UNMAPPED: assert property ($past(RD) && $past(unmapped) |-> RDATA == 8'h00)
    else $error("unmapped read returned data");
  AST_RESET_OUT: assert property ($past(RST) && $past(CE) |-> SERIAL_OUT_PIN && !RX_IRQ)
    else $error("outputs not idle after reset");
  AST_PLAIN_HOLD: assert property (!ir_ff && $changed(SERIAL_OUT_PIN) |=>
    $stable(SERIAL_OUT_PIN)[*7])
    else $error("plain serial bit shorter than eight clocks");
  AST_IR_PULSE: assert property (ir1 && $rose(SERIAL_OUT_PIN) |->
    SERIAL_OUT_PIN[*3] ##1 !SERIAL_OUT_PIN)
    else $error("infrared pulse not three clocks high");
  AST_IR_GAP: assert property (ir1 && $fell(SERIAL_OUT_PIN) |-> !SERIAL_OUT_PIN[*8])
    else $error("infrared low stretch too short");
  AST_IRQ_CLEAR: assert property (RD && ADDR == 12'hf40 |-> ##2 !RX_IRQ)
    else $error("interrupt stays after data read");
  AST_NODE_READ: assert property ($past(RD) && $past(ADDR) == 12'hf44 |-> RDATA == node_ff)
    else $error("node address readback wrong");
  AST_DIV_READ: assert property ($past(RD) && $past(ADDR) == 12'hf47 |-> RDATA == brl_ff)
    else $error("divisor readback wrong");
endmodule : umie_uart_sva
bind umie_uart umie_uart_sva u_sva (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SERIAL_IN_PIN(SERIAL_IN_PIN),
  .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .RX_IRQ(RX_IRQ));
`default_nettype wire

// ### sim/umie_uart_tb.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Read data valid the cycle after the read strobe
// Notes: Divisor two gives 32 clocks a bit on the plain link
`timescale 1ns/1ps
`default_nettype none
module umie_uart_tb;
  logic CLK_SYS, RST, CE, WR, RD, SERIAL_IN_PIN, SERIAL_OUT_PIN, RX_IRQ, s, p;
  logic [11:0] ADDR;
  logic [7:0] WDATA, RDATA, d;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  umie_uart dut (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SERIAL_IN_PIN(SERIAL_IN_PIN), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
    .RX_IRQ(RX_IRQ));
  umie_node #(.BIT_CYC(32)) node (.clk(CLK_SYS), .line_in(SERIAL_OUT_PIN),
    .line_out(SERIAL_IN_PIN));
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    // Sample mid-cycle while the answer stands
    @(negedge CLK_SYS);
    v = RDATA;
  endtask : rd
  task automatic wirq(output logic seen);
    seen = 1'b0;
    repeat (64) begin
      @(posedge CLK_SYS);
      if (RX_IRQ === 1'b1) seen = 1'b1;
    end
  endtask : wirq
  initial begin
    RST = 1'b1;
    CE = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 12'h000;
    WDATA = 8'h00;
    repeat (8) @(posedge CLK_SYS);
    RST <= 1'b0;
    rd(12'hf41, d);
    chk("tx_empty", 8'h04, d & 8'h04);
    rd(12'hf45, d);
    chk("unmapped", 8'h00, d);
    rd(12'hf47, d);
    chk("divisor_low", 8'h01, d);
    wr(12'hf42, 8'h80);
    wr(12'hf43, 8'h02);
    wr(12'hf40, 8'ha6);
    n = 0;
    p = SERIAL_OUT_PIN;
    repeat (240) begin
      @(posedge CLK_SYS);
      if (SERIAL_OUT_PIN && !p) n++;
      p = SERIAL_OUT_PIN;
    end
    chk("ir_pulses", 8'h05, n[7:0]);
    wr(12'hf43, 8'h00);
    // Let the idle level settle before the next frame
    repeat (8) @(posedge CLK_SYS);
    wr(12'hf47, 8'h02);
    wr(12'hf40, 8'h3c);
    node.recv(d);
    chk("tx_byte", 8'h3c, d);
    node.send(9'h011, 8);
    wirq(s);
    chk("irq_rx_off", 8'h00, {7'h00, s});
    wr(12'hf42, 8'hc0);
    node.send(9'h096, 8);
    wirq(s);
    chk("irq_data", 8'h01, {7'h00, s});
    rd(12'hf40, d);
    chk("rx_byte", 8'h96, d);
    wr(12'hf43, 8'h08);
    node.send(9'h05a, 8);
    wirq(s);
    chk("irq_err_only", 8'h00, {7'h00, s});
    rd(12'hf41, d);
    chk("rx_avail", 8'h80, d & 8'h80);
    rd(12'hf40, d);
    chk("rx_byte2", 8'h5a, d);
    wr(12'hf44, 8'h21);
    rd(12'hf44, d);
    chk("node_addr", 8'h21, d);
    // Write while frozen must not land
    @(posedge CLK_SYS);
    CE <= 1'b0;
    wr(12'hf44, 8'h7e);
    CE <= 1'b1;
    rd(12'hf44, d);
    chk("node_addr_frozen", 8'h21, d);
    wr(12'hf43, 8'he0);
    node.send(9'h133, 9);
    node.send(9'h044, 9);
    wirq(s);
    chk("irq_mismatch", 8'h00, {7'h00, s});
    node.send(9'h121, 9);
    node.send(9'h055, 9);
    wirq(s);
    chk("irq_match", 8'h01, {7'h00, s});
    rd(12'hf40, d);
    chk("rx_match", 8'h55, d);
    test_done();
  end
endmodule : umie_uart_tb
`default_nettype wire

// ### verilog/umie_consts.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Byte-wide register port, 12-bit address
// Notes: Shared by the serial core and the infrared encoder
`ifndef UMIE_CONSTS_SVH
`define UMIE_CONSTS_SVH

`define UMIE_OFS_DATA 12'hf40
`define UMIE_OFS_STAT 12'hf41
`define UMIE_OFS_CTL0 12'hf42
`define UMIE_OFS_CTL1 12'hf43
`define UMIE_OFS_ADDR 12'hf44
`define UMIE_OFS_BRH 12'hf46
`define UMIE_OFS_BRL 12'hf47

`define UMIE_C0_TEN 7
`define UMIE_C0_REN 6
`define UMIE_C0_PEN 4
`define UMIE_C0_PSEL 3
`define UMIE_C1_MPMD1 7
`define UMIE_C1_MULTIDROP_ENABLE 6
`define UMIE_C1_MPMD0 5
`define UMIE_C1_MPBT 4
`define UMIE_C1_RDAIRQ 3
`define UMIE_C1_IREN 1

`define UMIE_ST_RDA 7
`define UMIE_ST_PE 6
`define UMIE_ST_OE 5
`define UMIE_ST_FE 4
`define UMIE_ST_TDRE 2
`define UMIE_ST_TXE 1
`define UMIE_ST_MPRX 0

`define UMIE_BRG_RESET 16'h0001
`define UMIE_OVERSAMPLE 5'h10
`define UMIE_IR_LOW1 4'h7
`define UMIE_IR_HIGH 4'h3

`endif

// ### verilog/umie_ir_encoder.sv
// Purpose: Reshapes each serial bit into a 16-tick infrared pulse pattern
// Assumes: Tick is the baud clock at sixteen times the bit rate
// Notes: Bit frame aligned to the transmitter's tick phase
`timescale 1ns/1ps
`default_nettype none
`include "umie_consts.svh"
module umie_ir_encoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic en,
  input wire logic tick,
  input wire logic bit_start,
  input wire logic txd,
  output logic pulse
);
  logic [3:0] phase_ff, nxt_phase;
  logic pulse_ff, nxt_pulse;

  always_comb begin
    nxt_phase = phase_ff;
    nxt_pulse = pulse_ff;
    if (!en) begin
      nxt_phase = 4'h0;
      nxt_pulse = 1'b0;
    end else if (tick) begin
      nxt_phase = bit_start ? 4'h0 : phase_ff + 4'h1;
      // zero makes 7 low, 3 high, 6 low
      nxt_pulse = !txd && (nxt_phase >= `UMIE_IR_LOW1) &&
                  (nxt_phase < (`UMIE_IR_LOW1 + `UMIE_IR_HIGH));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_ff <= 4'h0;
      pulse_ff <= 1'b0;
    end else if (ce) begin
      phase_ff <= nxt_phase;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse = pulse_ff;
endmodule : umie_ir_encoder
`default_nettype wire

// ### verilog/umie_pkg.sv
// Purpose: Types shared by the serial core
// Assumes: Constants come from umie_consts.svh
// Notes: State codes are one-hot
package umie_pkg;
  typedef enum logic [3:0] {
    UMIE_TX_IDLE = 4'h1,
    UMIE_TX_START = 4'h2,
    UMIE_TX_BITS = 4'h4,
    UMIE_TX_STOP = 4'h8
  } umie_tx_e;
  typedef enum logic [3:0] {
    UMIE_RX_IDLE = 4'h1,
    UMIE_RX_START = 4'h2,
    UMIE_RX_BITS = 4'h4,
    UMIE_RX_STOP = 4'h8
  } umie_rx_e;
  typedef logic [7:0] umie_byte_t;
endpackage : umie_pkg

// ### verilog/umie_uart.sv
// Purpose: Serial port with multidrop matching and infrared transmit encoder
// Assumes: Register port strobes are one cycle, read data valid next cycle
// Notes: 9-bit mode carries the address flag as the ninth bit
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "umie_consts.svh"
// Behaviour
// - Transmit write and receive read share one register address
// - Byte written is shifted out on the serial output pin
// - Each received byte that passes the multidrop address filter is stored for software to read
// - Upper match select bit compares address bytes with node address
// - With comparison active, data available only after a matching address
// - Receive interrupt reports new data and receive errors
// - Software picks interrupt on data and errors, or errors only
// - Multidrop enable gives 9-bit mode; match select picks the scheme
// - Receiver enable bit enables reception
// - Infrared output built from serial output and baud clock
// - Each infrared bit lasts sixteen baud clocks
// - A one bit keeps the infrared output low throughout
// - A zero bit is low 7, high 3, low 6 clocks
// - With encoder on, the infrared pulse drives the transmit pin
// - Encoder works only while the serial port is enabled
// - Infrared bit rate is clock over sixteen times divisor
module umie_uart
  import umie_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_OUT_PIN,
  output logic RX_IRQ
);
  import umie_pkg::*;

  logic [7:0] ctl0_ff, nxt_ctl0, ctl1_ff, nxt_ctl1, node_addr_ff, nxt_node_addr;
  logic [15:0] brg_ff, nxt_brg, brg_cnt_ff, nxt_brg_cnt;
  logic tick;
  logic [7:0] rdata_ff, nxt_rdata;
  logic out_ff, nxt_out;
  logic irq_ff, nxt_irq;
  // Transmit
  umie_tx_e tx_st_ff, nxt_tx_st;
  umie_byte_t tx_hold_ff, nxt_tx_hold, tx_sh_ff, nxt_tx_sh;
  logic tx_full_ff, nxt_tx_full, tx_nine_ff, nxt_tx_nine, tx_par_ff, nxt_tx_par;
  logic [3:0] tx_ph_ff, nxt_tx_ph, tx_bit_ff, nxt_tx_bit;
  logic txd_ff, nxt_txd, bit_start_ff, nxt_bit_start;
  // Receive
  umie_rx_e rx_st_ff, nxt_rx_st;
  umie_byte_t rx_sh_ff, nxt_rx_sh, rx_hold_ff, nxt_rx_hold;
  logic [3:0] rx_ph_ff, nxt_rx_ph, rx_bit_ff, nxt_rx_bit;
  logic rx_nine_ff, nxt_rx_nine, rx_par_ff, nxt_rx_par;
  logic rda_ff, nxt_rda, pe_ff, nxt_pe, oe_ff, nxt_oe, fe_ff, nxt_fe;
  logic mprx_ff, nxt_mprx, matched_ff, nxt_matched;
  logic rx_s1_ff, rx_s2_ff;
  logic ir_pulse;

  // Register address decode used by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic port_en, mp_en, ir_en, extra_bit, data_done, rx_error, rx_accept;
  logic [7:0] status;
  assign port_en = ctl0_ff[`UMIE_C0_TEN] | ctl0_ff[`UMIE_C0_REN];
  assign mp_en = ctl1_ff[`UMIE_C1_MULTIDROP_ENABLE];
  assign ir_en = ctl1_ff[`UMIE_C1_IREN] & port_en;
  assign extra_bit = mp_en | ctl0_ff[`UMIE_C0_PEN];
  assign status = {rda_ff, pe_ff, oe_ff, fe_ff, 1'b0, !tx_full_ff,
                   (tx_st_ff == UMIE_TX_IDLE) && !tx_full_ff, mprx_ff};

  // Baud generator and registers
  always_comb begin
    nxt_ctl0 = ctl0_ff;
    nxt_ctl1 = ctl1_ff;
    nxt_node_addr = node_addr_ff;
    nxt_brg = brg_ff;
    nxt_rdata = 8'h00;
    // tick every divisor clocks, bit every 16 ticks
    tick = (brg_cnt_ff <= 16'h0001);
    nxt_brg_cnt = tick ? brg_ff : brg_cnt_ff - 16'h0001;
    if (WR) begin
      if (hit(ADDR, `UMIE_OFS_CTL0)) nxt_ctl0 = WDATA;
      if (hit(ADDR, `UMIE_OFS_CTL1)) nxt_ctl1 = WDATA;
      if (hit(ADDR, `UMIE_OFS_ADDR)) nxt_node_addr = WDATA;
      if (hit(ADDR, `UMIE_OFS_BRH)) nxt_brg = {WDATA, brg_ff[7:0]};
      if (hit(ADDR, `UMIE_OFS_BRL)) nxt_brg = {brg_ff[15:8], WDATA};
    end
    if (RD) begin
      if (hit(ADDR, `UMIE_OFS_DATA)) nxt_rdata = rx_hold_ff;
      if (hit(ADDR, `UMIE_OFS_STAT)) nxt_rdata = status;
      if (hit(ADDR, `UMIE_OFS_CTL0)) nxt_rdata = ctl0_ff;
      if (hit(ADDR, `UMIE_OFS_CTL1)) nxt_rdata = ctl1_ff;
      if (hit(ADDR, `UMIE_OFS_ADDR)) nxt_rdata = node_addr_ff;
      if (hit(ADDR, `UMIE_OFS_BRH)) nxt_rdata = brg_ff[15:8];
      if (hit(ADDR, `UMIE_OFS_BRL)) nxt_rdata = brg_ff[7:0];
    end
  end

  // Transmitter
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_hold = tx_hold_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_full = tx_full_ff;
    nxt_tx_nine = tx_nine_ff;
    nxt_tx_par = tx_par_ff;
    nxt_tx_ph = tx_ph_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_txd = txd_ff;
    nxt_bit_start = 1'b0;
    if (WR && hit(ADDR, `UMIE_OFS_DATA)) begin
      nxt_tx_hold = WDATA;
      nxt_tx_full = 1'b1;
    end
    if (tick) begin
      nxt_tx_ph = tx_ph_ff + 4'h1;
      nxt_bit_start = (tx_ph_ff == 4'hf);
    end
    case (tx_st_ff)
      UMIE_TX_IDLE: begin
        nxt_txd = 1'b1;
        if (tx_full_ff && ctl0_ff[`UMIE_C0_TEN] && tick && tx_ph_ff == 4'hf) begin
          nxt_tx_sh = tx_hold_ff;
          nxt_tx_full = WR && hit(ADDR, `UMIE_OFS_DATA);
          nxt_tx_nine = mp_en ? ctl1_ff[`UMIE_C1_MPBT] : ^{tx_hold_ff, ctl0_ff[`UMIE_C0_PSEL]};
          nxt_txd = 1'b0;
          nxt_tx_st = UMIE_TX_START;
        end
      end
      UMIE_TX_START: if (tick && tx_ph_ff == 4'hf) begin
        nxt_tx_bit = 4'h0;
        nxt_txd = tx_sh_ff[0];
        nxt_tx_st = UMIE_TX_BITS;
      end
      UMIE_TX_BITS: if (tick && tx_ph_ff == 4'hf) begin
        nxt_tx_bit = tx_bit_ff + 4'h1;
        nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
        if (tx_bit_ff == 4'h7 && extra_bit) nxt_txd = tx_nine_ff;
        else if (tx_bit_ff >= 4'h7) begin
          nxt_txd = 1'b1;
          nxt_tx_st = UMIE_TX_STOP;
        end else nxt_txd = tx_sh_ff[1];
      end
      UMIE_TX_STOP: if (tick && tx_ph_ff == 4'hf) nxt_tx_st = UMIE_TX_IDLE;
      default: nxt_tx_st = UMIE_TX_IDLE;
    endcase
    nxt_tx_par = 1'b0;
  end

  // Receiver
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_hold = rx_hold_ff;
    nxt_rx_ph = rx_ph_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_nine = rx_nine_ff;
    nxt_rx_par = rx_par_ff;
    nxt_rda = rda_ff;
    nxt_pe = pe_ff;
    nxt_oe = oe_ff;
    nxt_fe = fe_ff;
    nxt_mprx = mprx_ff;
    nxt_matched = matched_ff;
    data_done = 1'b0;
    rx_accept = 1'b0;
    // Reading data clears data flag and errors; a new event wins below
    if (RD && hit(ADDR, `UMIE_OFS_DATA)) begin
      nxt_rda = 1'b0;
      nxt_pe = 1'b0;
      nxt_oe = 1'b0;
      nxt_fe = 1'b0;
    end
    if (tick) nxt_rx_ph = rx_ph_ff + 4'h1;
    case (rx_st_ff)
      UMIE_RX_IDLE: begin
        if (tick && ctl0_ff[`UMIE_C0_REN] && !rx_s2_ff) begin
          nxt_rx_ph = 4'h1;
          nxt_rx_st = UMIE_RX_START;
        end
      end
      UMIE_RX_START: if (tick && rx_ph_ff == 4'h7) begin
        nxt_rx_ph = 4'h8;
        nxt_rx_bit = 4'h0;
        nxt_rx_st = rx_s2_ff ? UMIE_RX_IDLE : UMIE_RX_BITS;
      end
      UMIE_RX_BITS: if (tick && rx_ph_ff == 4'h7) begin
        nxt_rx_bit = rx_bit_ff + 4'h1;
        if (rx_bit_ff < 4'h8) nxt_rx_sh = {rx_s2_ff, rx_sh_ff[7:1]};
        else nxt_rx_nine = rx_s2_ff;
        if (rx_bit_ff == (extra_bit ? 4'h8 : 4'h7)) nxt_rx_st = UMIE_RX_STOP;
      end
      UMIE_RX_STOP: if (tick && rx_ph_ff == 4'h7) begin
        nxt_rx_st = UMIE_RX_IDLE;
        data_done = 1'b1;
      end
      default: nxt_rx_st = UMIE_RX_IDLE;
    endcase
    if (data_done) begin
      // address bytes compared when upper select set
      if (mp_en && rx_nine_ff) begin
        nxt_matched = !ctl1_ff[`UMIE_C1_MPMD1] || (rx_sh_ff == node_addr_ff);
        rx_accept = !ctl1_ff[`UMIE_C1_MPMD0] && nxt_matched;
      end else begin
        // with comparison active, data only passes after a match
        rx_accept = !(mp_en && ctl1_ff[`UMIE_C1_MPMD1]) || matched_ff;
      end
      if (rx_accept) begin
        nxt_rx_hold = rx_sh_ff;
        nxt_mprx = rx_nine_ff;
        nxt_rda = 1'b1;
        nxt_oe = rda_ff && !(RD && hit(ADDR, `UMIE_OFS_DATA));
        nxt_fe = !rx_s2_ff;
        nxt_pe = !mp_en && ctl0_ff[`UMIE_C0_PEN] &&
                 (^{rx_sh_ff, rx_nine_ff, ctl0_ff[`UMIE_C0_PSEL]});
      end
    end
    nxt_rx_par = 1'b0;
  end

  assign rx_error = nxt_pe | nxt_oe | nxt_fe;
  always_comb begin
    nxt_irq = rx_error | (nxt_rda & !ctl1_ff[`UMIE_C1_RDAIRQ]);
    nxt_out = ir_en ? ir_pulse : txd_ff;
  end

  // encoder fed by serial output and baud tick
  umie_ir_encoder u_ir (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .en(ir_en),
    .tick(tick),
    .bit_start(nxt_bit_start),
    .txd(nxt_txd),
    .pulse(ir_pulse)
  );

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctl0_ff <= 8'h00;
      ctl1_ff <= 8'h00;
      node_addr_ff <= 8'h00;
      brg_ff <= `UMIE_BRG_RESET;
      brg_cnt_ff <= `UMIE_BRG_RESET;
      rdata_ff <= 8'h00;
      out_ff <= 1'b1;
      irq_ff <= 1'b0;
      tx_st_ff <= UMIE_TX_IDLE;
      tx_hold_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      tx_full_ff <= 1'b0;
      tx_nine_ff <= 1'b0;
      tx_par_ff <= 1'b0;
      tx_ph_ff <= 4'h0;
      tx_bit_ff <= 4'h0;
      txd_ff <= 1'b1;
      bit_start_ff <= 1'b0;
      rx_st_ff <= UMIE_RX_IDLE;
      rx_sh_ff <= 8'h00;
      rx_hold_ff <= 8'h00;
      rx_ph_ff <= 4'h0;
      rx_bit_ff <= 4'h0;
      rx_nine_ff <= 1'b0;
      rx_par_ff <= 1'b0;
      rda_ff <= 1'b0;
      pe_ff <= 1'b0;
      oe_ff <= 1'b0;
      fe_ff <= 1'b0;
      mprx_ff <= 1'b0;
      matched_ff <= 1'b0;
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end else if (CE) begin
      ctl0_ff <= nxt_ctl0;
      ctl1_ff <= nxt_ctl1;
      node_addr_ff <= nxt_node_addr;
      brg_ff <= nxt_brg;
      brg_cnt_ff <= nxt_brg_cnt;
      rdata_ff <= nxt_rdata;
      out_ff <= nxt_out;
      irq_ff <= nxt_irq;
      tx_st_ff <= nxt_tx_st;
      tx_hold_ff <= nxt_tx_hold;
      tx_sh_ff <= nxt_tx_sh;
      tx_full_ff <= nxt_tx_full;
      tx_nine_ff <= nxt_tx_nine;
      tx_par_ff <= nxt_tx_par;
      tx_ph_ff <= nxt_tx_ph;
      tx_bit_ff <= nxt_tx_bit;
      txd_ff <= nxt_txd;
      bit_start_ff <= nxt_bit_start;
      rx_st_ff <= nxt_rx_st;
      rx_sh_ff <= nxt_rx_sh;
      rx_hold_ff <= nxt_rx_hold;
      rx_ph_ff <= nxt_rx_ph;
      rx_bit_ff <= nxt_rx_bit;
      rx_nine_ff <= nxt_rx_nine;
      rx_par_ff <= nxt_rx_par;
      rda_ff <= nxt_rda;
      pe_ff <= nxt_pe;
      oe_ff <= nxt_oe;
      fe_ff <= nxt_fe;
      mprx_ff <= nxt_mprx;
      matched_ff <= nxt_matched;
      rx_s1_ff <= SERIAL_IN_PIN;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  assign RDATA = rdata_ff;
  assign SERIAL_OUT_PIN = out_ff;
  assign RX_IRQ = irq_ff;
endmodule : umie_uart
`default_nettype wire
